// File: logic/fbm_ctrl.sv
// Bus master that runs read and write cycles on a bytewide nonvolatile memory.
// What this block does
// - Address may change only after the hold interval past chip select falling.
// - Master holds write data stable through setup before the write ends.
// - Master holds chip select high for the minimum precharge between cycles.
// - Precharge starts only on chip select rising; master bounds the low time.
// - Master keeps chip select low between 70 ns and 2000 ns.
`timescale 1ns/1ns
module fbm_ctrl
  import fbm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire fbm_req_s          req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic                   rsp_write,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic [ADDR_W-ROW_LSB-1:0] rsp_row,
  output fbm_pin_s               pins,
  input  wire logic [DATA_W-1:0] data_bus_in
);

  localparam int A_LOW = LOW_CYC;
  localparam int A_MAX = CA_MAX_CYC;
  localparam int A_PC  = PC_CYC;

  fbm_state_e        state;
  logic              cur_write;
  logic              ce_n;
  logic              oe_n;
  logic              we_n;
  logic [ADDR_W-1:0] address_lines;
  logic [DATA_W-1:0] data_bus_out;
  logic              data_bus_oe;
  logic       tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic       tmr_done;

  assign req_ready = (state == ST_IDLE);

  // The pin group is assembled in one place so that every field keeps a single driver.
  assign pins = '{
    ce_n:          ce_n,
    oe_n:          oe_n,
    we_n:          we_n,
    address_lines: address_lines,
    data_bus_out:  data_bus_out,
    data_bus_oe:   data_bus_oe
  };

  always_comb
  begin
    tmr_load = 1'b0;
    tmr_val  = TMR_W'(LOW_CYC);
    case (state)
      ST_SETUP:
      begin
        tmr_load = 1'b1;
        tmr_val  = TMR_W'(LOW_CYC);
      end
      ST_LOW:
      begin
        tmr_load = tmr_done;
        tmr_val  = TMR_W'(PC_CYC);
      end
      default:
      begin
        tmr_load = 1'b0;
        tmr_val  = TMR_W'(LOW_CYC);
      end
    endcase
  end

  fbm_tmr #(.W(TMR_W)) u_tmr
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // Sequencer: address setup, chip select low phase, precharge.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= ST_IDLE;
    else
      case (state)
        ST_IDLE:
          if (req_valid)
            state <= ST_SETUP;
        ST_SETUP:
          state <= ST_LOW;
        ST_LOW:
          if (tmr_done)
            state <= ST_PRE;
        ST_PRE:
          if (tmr_done)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
  end

  // Address and write data are presented before select falls and held to the end.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      address_lines <= ADDR_RST;
      data_bus_out  <= DATA_RST;
      cur_write     <= 1'b0;
    end
    else if (state == ST_IDLE && req_valid)
    begin
      address_lines <= req.addr;
      data_bus_out  <= req.wdata;
      cur_write     <= req.write;
    end
  end

  // Chip select: falls one cycle after setup, rises after the low phase.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ce_n <= 1'b1;
    else if (state == ST_SETUP)
      ce_n <= 1'b0;
    else if (state == ST_LOW && tmr_done)
      ce_n <= 1'b1;
  end

  // Writes lower write enable before select falls so the memory never drives.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      we_n <= 1'b1;
    else if (state == ST_IDLE && req_valid)
      we_n <= !req.write;
    else if (state == ST_LOW && tmr_done)
      we_n <= 1'b1;
  end

  // Output gating is low only during the low phase of a read.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      oe_n <= 1'b1;
    else if (state == ST_SETUP)
      oe_n <= cur_write;
    else if (state == ST_LOW && tmr_done)
      oe_n <= 1'b1;
  end

  // Write data is driven from setup until precharge ends, past the write end.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      data_bus_oe <= 1'b0;
    else if (state == ST_IDLE && req_valid)
      data_bus_oe <= req.write;
    else if (state == ST_PRE && tmr_done)
      data_bus_oe <= 1'b0;
  end

  // Read data is sampled at the end of the low phase, after the access time.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_write <= 1'b0;
      rsp_rdata <= DATA_RST;
      rsp_row   <= '0;
    end
    else
    begin
      rsp_valid <= (state == ST_LOW) && tmr_done;
      if (state == ST_LOW && tmr_done)
      begin
        rsp_write <= cur_write;
        rsp_row   <= address_lines[ADDR_W-1:ROW_LSB];
        if (!cur_write)
          rsp_rdata <= data_bus_in;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ce_low_exact:  assert property ($fell(pins.ce_n) |-> ##A_LOW $rose(pins.ce_n))
    else $error("Chip select low time wrong.");
  a_ce_low_max:    assert property ($fell(pins.ce_n) |-> ##[1:A_MAX] $rose(pins.ce_n))
    else $error("Chip select held low too long.");
  a_precharge_min: assert property ($rose(pins.ce_n) |-> pins.ce_n [*2])
    else $error("Precharge too short.");
  a_pc_count:      assert property ($rose(pins.ce_n) |-> ##A_PC (state == ST_IDLE))
    else $error("Precharge phase length wrong.");
  a_addr_hold:     assert property ($fell(pins.ce_n) |-> $stable(pins.address_lines) ##1 $stable(pins.address_lines))
    else $error("Address changed inside a cycle.");
  a_wdata_stable:  assert property (!pins.we_n && !$fell(pins.we_n) |-> $stable(pins.data_bus_out) && pins.data_bus_oe)
    else $error("Write data moved before the write ended.");
  a_we_before_ce:  assert property ($fell(pins.ce_n) && cur_write |-> !$past(pins.we_n) && pins.oe_n)
    else $error("Write enable not low before select fell.");
  a_no_contention: assert property (pins.data_bus_oe |-> pins.oe_n)
    else $error("Both ends may drive the data bus.");
  a_rsp_timing:    assert property ($fell(pins.ce_n) |-> ##A_LOW rsp_valid)
    else $error("Answer not given at end of access.");
  a_ready_idle:    assert property (req_ready |-> pins.ce_n && pins.we_n)
    else $error("Ready while a cycle is open.");

  c_read:     cover property ($fell(pins.ce_n) && pins.we_n);
  c_write:    cover property ($fell(pins.ce_n) && !pins.we_n);
  c_wr_rd:    cover property (rsp_valid && rsp_write ##[1:4] $fell(pins.ce_n) && pins.we_n);
  c_b2b_req:  cover property (rsp_valid ##[1:3] (req_valid && req_ready));

endmodule : fbm_ctrl

// File: logic/fbm_pkg.sv
// Shared constants and carrier types for the bytewide memory port controller.
package fbm_pkg;

  localparam int ADDR_W        = 15;
  localparam int DATA_W        = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_CE_NS       = 70;
  localparam int T_CA_MIN_NS   = 70;
  localparam int T_CA_MAX_NS   = 2000;
  localparam int T_PC_NS       = 60;
  localparam int T_RC_NS       = 130;
  localparam int T_AH_NS       = 10;

  localparam int ACC_CYC    = (T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CA_MIN_CYC = (T_CA_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CA_MAX_CYC = T_CA_MAX_NS / CLK_PERIOD_NS;
  localparam int AH_CYC     = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_RAW    = (ACC_CYC > CA_MIN_CYC) ? ACC_CYC : CA_MIN_CYC;
  localparam int LOW_CYC    = (LOW_RAW > AH_CYC) ? LOW_RAW : AH_CYC;
  localparam int PC_RAW     = (T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC     = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PC_CYC     = (PC_RAW > RC_CYC - LOW_CYC) ? PC_RAW : RC_CYC - LOW_CYC;
  localparam int TMR_W      = 5;
  localparam int ROW_LSB    = 2;

  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'h1,
    ST_SETUP = 4'h2,
    ST_LOW   = 4'h4,
    ST_PRE   = 4'h8
  } fbm_state_e;

  typedef struct packed
  {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fbm_req_s;

  typedef struct packed
  {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] address_lines;
    logic [DATA_W-1:0] data_bus_out;
    logic              data_bus_oe;
  } fbm_pin_s;

endpackage : fbm_pkg

// File: logic/fbm_tmr.sv
// Down counter that times one phase of a memory cycle.
`timescale 1ns/1ns
module fbm_tmr
  import fbm_pkg::*;
#(
  parameter int W = TMR_W
)
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] count;

  // Loading n makes done rise after n-1 further edges.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      count <= '0;
    else if (load)
      count <= load_val - W'(1);
    else if (count != '0)
      count <= count - W'(1);
  end

  assign done = (count == '0);

endmodule : fbm_tmr

// File: tb/fbm_mem_model.sv
// Behavioural model of the bytewide nonvolatile memory seen by the controller.
`timescale 1ns/1ns
module fbm_mem_model
  import fbm_pkg::*;
(
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [ADDR_W-1:0] address_lines,
  input  wire logic [DATA_W-1:0] data_bus,
  output logic [DATA_W-1:0]      q,
  output logic                   q_oe
);
  logic [DATA_W-1:0]         mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0]         lat_addr = '0;
  logic [ADDR_W-ROW_LSB-1:0] row      = '0;
  logic                      wr_cyc   = 1'b0;
  logic                      wr_open  = 1'b0;
  logic                      valid    = 1'b0;
  logic                      ce_last  = 1'b1;
  logic                      we_last  = 1'b1;
  assign q    = mem[lat_addr];
  assign q_oe = !ce_n && !oe_n && valid && !wr_cyc;
  // Edges are found against the last levels, so one process owns the cycle state.
  always @(ce_n or we_n)
  begin
    if (ce_last && !ce_n)
    begin
      lat_addr = address_lines;
      row      = address_lines[ADDR_W-1:ROW_LSB];
      wr_cyc   = !we_n;
      wr_open  = !we_n;
    end
    else if (!ce_n && we_last && !we_n)
    begin
      wr_cyc  = 1'b1;
      wr_open = 1'b1;
    end
    if (wr_open && ((!we_last && we_n) || (!ce_last && ce_n)))
    begin
      mem[lat_addr] = data_bus;
      wr_open       = 1'b0;
    end
    ce_last = ce_n;
    we_last = we_n;
  end
  always @(negedge ce_n)
  begin
    valid = 1'b0;
    #(T_CE_NS) valid = 1'b1;
  end
endmodule : fbm_mem_model

// File: tb/test_ferroelectric_bytewide_memory_port.sv
// Self-checking bench for the bytewide memory port controller.
`timescale 1ns/1ns
module test_ferroelectric_bytewide_memory_port
  import fbm_pkg::*;
;
  logic                      clk = 1'b0;
  logic                      sys_rst = 1'b1;
  fbm_req_s                  req = '0;
  logic                      req_valid = 1'b0;
  logic                      req_ready;
  logic                      rsp_valid;
  logic                      rsp_write;
  logic [DATA_W-1:0]         rsp_rdata;
  logic [ADDR_W-ROW_LSB-1:0] rsp_row;
  fbm_pin_s                  pins;
  logic [DATA_W-1:0]         data_bus_in;
  logic [DATA_W-1:0]         dev_q;
  logic                      dev_oe;
  logic [DATA_W-1:0]         bus_last = 8'h00;
  logic [ADDR_W-1:0]         cur_addr = '0;
  int                        err_count = 0;
  int                        total_checks = 0;
  int                        cycles = 0;
  int                        low_len = 0;
  int                        high_len = 9;
  logic [ADDR_W-1:0]         adr [4] = '{15'h0000, 15'h7FFF, 15'h4001, 15'h0001};

  always #(CLK_PERIOD_NS/2) clk = ~clk;
  // An undriven bus shows the inverse of its last level.
  assign data_bus_in = pins.data_bus_oe ? pins.data_bus_out : (dev_oe ? dev_q : ~bus_last);
  always @(posedge clk) bus_last <= data_bus_in;

  fbm_ctrl u_fbm_ctrl (.clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_write(rsp_write), .rsp_rdata(rsp_rdata), .rsp_row(rsp_row), .pins(pins),
    .data_bus_in(data_bus_in));
  fbm_mem_model u_fbm_mem_model (.ce_n(pins.ce_n), .oe_n(pins.oe_n), .we_n(pins.we_n),
    .address_lines(pins.address_lines), .data_bus(data_bus_in), .q(dev_q), .q_oe(dev_oe));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  always @(posedge clk)
  begin
    if (!sys_rst)
    begin
      cycles <= cycles + 1;
      if (dev_oe) check(pins.data_bus_oe, 1'b0);
      if (!pins.ce_n)
      begin
        if (low_len == 0) check(high_len >= 2, 1'b1);
        check(pins.address_lines, cur_addr);
        check(pins.oe_n ^ pins.we_n, 1'b1);
        low_len  <= low_len + 1;
        high_len <= 0;
      end
      else
      begin
        if (low_len != 0) check(low_len, LOW_CYC);
        low_len  <= 0;
        high_len <= high_len + 1;
      end
      if (cycles == 3000)
      begin
        err_count++;
        print_verdict();
      end
    end
  end

  task automatic do_op(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req       <= '{write: wr, addr: a, wdata: d};
    req_valid <= 1'b1;
    do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 50);
    cur_addr = a;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (rsp_valid !== 1'b1 && n < 10);
    check(n, 3);
    check(rsp_write, wr);
    check(rsp_row, a[ADDR_W-1:ROW_LSB]);
    if (!wr) check(rsp_rdata, d);
  endtask : do_op

  task automatic t_reset();
    check({pins.ce_n, pins.oe_n, pins.we_n, pins.data_bus_oe, req_ready, rsp_valid}, 6'h3A);
    check(dev_oe, 1'b0);
    $display("Reset test done");
  endtask : t_reset

  task automatic t_back2back();
    do_op(1'b1, 15'h0123, 8'hA5);
    do_op(1'b0, 15'h0123, 8'hA5);
    do_op(1'b1, 15'h0124, 8'h3C);
    do_op(1'b0, 15'h0123, 8'hA5);
    do_op(1'b0, 15'h0124, 8'h3C);
    $display("Back to back test done");
  endtask : t_back2back

  task automatic t_bounds();
    for (int i = 0; i < 4; i++) do_op(1'b1, adr[i], 8'h11 * (i + 1));
    for (int i = 0; i < 4; i++) do_op(1'b0, adr[i], 8'h11 * (i + 1));
    $display("Address bounds test done");
  endtask : t_bounds

  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_back2back();
    t_bounds();
    print_verdict();
  end
endmodule : test_ferroelectric_bytewide_memory_port
